/* bench/link_monitor.sv */
// Purpose: Wire checks on port 0 of the serial link pair.
// Assumes: Port 0 runs at four ref_clk cycles a bit on both ends.
// Notes: Lane 0 is device to host, lane 1 is host to device.

`timescale 1ns/10ps

module link_monitor (
	// Clock and reset
	input logic       ref_clk,
	input logic       reset,
	// Serial lines
	input logic [3:0] dev_to_host,
	input logic [3:0] host_to_dev
);

	// --------------------------------------------------------------
	// Frame trackers
	// --------------------------------------------------------------
	logic [1:0]      ln;
	logic [1:0][5:0] cnt_reg, cnt_next;
	logic [1:0]      dat_reg, dat_next, owe_reg, owe_next;
	logic [6:0]      hi_reg, hi_next;

	assign ln = {host_to_dev[0], dev_to_host[0]};

	always_comb
	begin
		hi_next = ln[0] ? hi_reg + 7'h01 : 7'h00;
		for (int i = 0; i < 2; i++)
		begin
			dat_next[i] = (cnt_reg[i] == 6'h04) ? ln[i] : dat_reg[i];
			owe_next[i] = owe_reg[i] && !(cnt_reg[1 - i] == 6'h04 && !ln[1 - i]);
			if (cnt_reg[i] == 6'h04 && ln[i])
				owe_next[i] = 1'b1;
			if (cnt_reg[i] == 6'h00)
				cnt_next[i] = {5'h00, ln[i]};
			else if ((cnt_reg[i] == 6'h07 && !dat_reg[i]) || cnt_reg[i] == 6'h2b)
				cnt_next[i] = 6'h00;
			else
				cnt_next[i] = cnt_reg[i] + 6'h01;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cnt_reg <= '0;
			dat_reg <= '0;
			owe_reg <= '0;
			hi_reg  <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			dat_reg <= dat_next;
			owe_reg <= owe_next;
			hi_reg  <= hi_next;
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	property p_idle_after_reset; $fell(reset) |-> dev_to_host == 4'h0 && host_to_dev == 4'h0; endproperty
	a_idle_after_reset: assert property (p_idle_after_reset) else $error("lines not idle after reset");
	property p_start_bit; cnt_reg[0] == 6'h00 && ln[0] |-> ln[0] [*4]; endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit too short");
	property p_stop_low; cnt_reg[0] == 6'h28 && dat_reg[0] |-> !ln[0] [*4]; endproperty
	a_stop_low: assert property (p_stop_low) else $error("stop bit not low");
	property p_ack_zero; cnt_reg[1] == 6'h04 && !ln[1] |-> !ln[1] [*4]; endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("acknowledge zero bit broken");
	property p_wait_dev; cnt_reg[0] == 6'h04 && owe_reg[0] |-> !ln[0]; endproperty
	a_wait_dev: assert property (p_wait_dev) else $error("device data before acknowledge");
	property p_wait_host; cnt_reg[1] == 6'h04 && owe_reg[1] |-> !ln[1]; endproperty
	a_wait_host: assert property (p_wait_host) else $error("host data before acknowledge");
	property p_ack_paired; cnt_reg[0] == 6'h04 && !ln[0] |-> owe_reg[1]; endproperty
	a_ack_paired: assert property (p_ack_paired) else $error("acknowledge without data");
	property p_high_run; hi_reg <= 7'h28; endproperty
	a_high_run: assert property (p_high_run) else $error("line high too long");

endmodule // link_monitor

/* bench/test_bidir_serial_link_port.sv */
// Purpose: Self-checking bench for the serial link pair.
// Assumes: Port 0 stays at 10 Mbit/s on both ends.
// Notes: Side 0 is the device end, side 1 the host end.

`timescale 1ns/10ps

module test_bidir_serial_link_port;

	// --------------------------------------------------------------
	// Signals and instances
	// --------------------------------------------------------------
	logic                 ref_clk, reset, glob, p0_sel, p123_sel;
	logic [3:0]           h_sel;
	logic [1:0][3:0][7:0] tx_data, rx_data;
	logic [1:0][3:0]      tx_valid, tx_last, tx_ready, tx_done, rx_valid, rx_ready;
	int                   failures, checked;
	int                   dones = 0;
	int                   hdones = 0;

	link_if i_link_if ();
	link_device i_link_device (.ref_clk(ref_clk), .reset(reset), .global_rate_select(glob),
		.port0_rate_select(p0_sel), .ports123_rate_select(p123_sel), .lnk(i_link_if.device_end),
		.tx_data(tx_data[0]), .tx_valid(tx_valid[0]), .tx_last(tx_last[0]), .tx_ready(tx_ready[0]),
		.tx_done(tx_done[0]), .rx_data(rx_data[0]), .rx_valid(rx_valid[0]), .rx_ready(rx_ready[0]));
	link_host i_link_host (.ref_clk(ref_clk), .reset(reset), .global_rate_select(glob),
		.per_port_rate_select(h_sel), .lnk(i_link_if.host_end),
		.tx_data(tx_data[1]), .tx_valid(tx_valid[1]), .tx_last(tx_last[1]), .tx_ready(tx_ready[1]),
		.tx_done(tx_done[1]), .rx_data(rx_data[1]), .rx_valid(rx_valid[1]), .rx_ready(rx_ready[1]));
	link_monitor i_link_monitor (.ref_clk(ref_clk), .reset(reset),
		.dev_to_host(i_link_if.dev_to_host), .host_to_dev(i_link_if.host_to_dev));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		dones <= dones + $countones(tx_done[0]);
		hdones <= hdones + $countones(tx_done[1]);
	end

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic expire(string what);
		check(what, 32'h0, 32'h1);
		test_done();
	endtask

	task automatic send(int s, int p, logic [7:0] b, logic last);
		tick();
		tx_data[s][p] = b;
		tx_last[s][p] = last;
		tx_valid[s][p] = 1'b1;
		for (int n = 0; tx_ready[s][p] !== 1'b1; n++)
		begin
			if (n > 3000)
				expire("tx_ready wait");
			tick();
		end
		tick();
		tx_valid[s][p] = 1'b0;
	endtask

	task automatic recv(int s, int p, logic [7:0] exp);
		tick();
		rx_ready[s][p] = 1'b1;
		for (int n = 0; rx_valid[s][p] !== 1'b1; n++)
		begin
			if (n > 3000)
				expire("rx_valid wait");
			tick();
		end
		check("rx_data", rx_data[s][p], exp);
		tick();
		rx_ready[s][p] = 1'b0;
	endtask

	task automatic rise(int p);
		for (int n = 0; i_link_if.dev_to_host[p] !== 1'b1; n++)
		begin
			if (n > 3000)
				expire("start bit wait");
			tick();
		end
	endtask

	task automatic grab(int p, output logic [10:0] w);
		rise(p);
		repeat (2) tick();
		for (int k = 0; k < 11; k++)
		begin
			w[k] = i_link_if.dev_to_host[p];
			repeat (4) tick();
		end
	endtask

	task automatic hi_run(int p, output int n);
		rise(p);
		for (n = 0; i_link_if.dev_to_host[p] === 1'b1; n++)
		begin
			if (n > 100)
				expire("high run");
			tick();
		end
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic s_frames();
		logic [10:0] w;
		logic [7:0]  b;
		for (int p = 0; p < 4; p++)
		begin
			b = 8'h96 + 8'(p);
			fork
				send(0, p, b, 1'b0);
				send(1, p, ~b, 1'b0);
				grab(p, w);
			join
			check("frame", w, {21'h0, 1'b0, b, 2'b11});
			recv(1, p, b);
			recv(0, p, ~b);
		end
	endtask

	task automatic s_message();
		int d0;
		d0 = dones;
		send(0, 2, 8'h11, 1'b0);
		send(0, 2, 8'h22, 1'b0);
		send(0, 2, 8'h33, 1'b1);
		for (int n = 0; tx_ready[0][2] !== 1'b1; n++)
		begin
			if (n > 3000)
				expire("second acknowledge");
			tick();
		end
		check("early done", dones - d0, 0);
		for (int n = 0; dones - d0 < 1; n++)
		begin
			if (n > 3000)
				expire("done wait");
			tick();
		end
		check("done count", dones - d0, 1);
		recv(1, 2, 8'h11);
		recv(1, 2, 8'h22);
		recv(1, 2, 8'h33);
	endtask

	task automatic s_fill();
		int h0;
		h0 = hdones;
		fork
			for (int i = 0; i < 17; i++)
				send(1, 3, 8'h40 + 8'(i), i == 16);
			for (int i = 0; i < 4; i++)
				send(0, 3, 8'h80 + 8'(i), 1'b0);
		join
		repeat (100) tick();
		check("full refuses", tx_ready[1][3], 1'b0);
		check("fifo holds", rx_valid[0][3], 1'b1);
		check("host early done", hdones - h0, 0);
		for (int i = 0; i < 4; i++)
			recv(1, 3, 8'h80 + 8'(i));
		for (int i = 0; i < 17; i++)
			recv(0, 3, 8'h40 + 8'(i));
		check("fifo empty", rx_valid[0][3], 1'b0);
		for (int n = 0; hdones - h0 < 1; n++)
		begin
			if (n > 3000)
				expire("host done wait");
			tick();
		end
		check("host done", hdones - h0, 1);
	endtask

	task automatic s_rates();
		int bt [4] = '{4, 8, 4, 2};
		int n0, n1;
		for (int r = 0; r < 4; r++)
		begin
			repeat (20) tick();
			glob = r[1];
			p123_sel = r[0];
			h_sel = {{3{r[0]}}, 1'b0};
			repeat (10) tick();
			fork
				send(0, 1, 8'h00, 1'b0);
				send(0, 0, 8'h00, 1'b0);
				hi_run(1, n1);
				hi_run(0, n0);
			join
			check("port1 bit time", n1, 2 * bt[r]);
			check("port0 bit time", n0, 8);
			recv(1, 1, 8'h00);
			recv(1, 0, 8'h00);
		end
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		glob = 1'b0;
		p0_sel = 1'b0;
		p123_sel = 1'b0;
		h_sel = 4'h0;
		tx_data = '0;
		tx_valid = '0;
		tx_last = '0;
		rx_ready = '0;
		failures = 0;
		checked = 0;
		repeat (6) tick();
		reset = 1'b0;
		repeat (8) tick();
		check("idle lines", {i_link_if.host_to_dev, i_link_if.dev_to_host}, 8'h00);
		s_frames();
		s_message();
		s_fill();
		s_rates();
		test_done();
	end

endmodule // test_bidir_serial_link_port

/* rtl/link_device.sv */
// Purpose: Four-port serial link device with receive FIFO per port.
// Assumes: Partner keeps the same packet and acknowledge discipline.
// Notes: Bit time is 2, 4 or 8 ref_clk cycles.
//
// Functional notes
// R1: Four identical ports, separate in and out.
// R2: Transmit line low when not sending.
// R3: Data packet: high, one, eight bits, low.
// R4: Data bits sent least significant first.
// R5: Acknowledge is high then zero, two bits.
// R6: Each received byte acknowledged on same port.
// R7: Next byte waits for acknowledge received.
// R8: Acknowledge only when buffer can take more.
// R9: Message completion reported after final acknowledge.
// R10: Rate from global and per-port select pins.
// R11: Port 0 own select, ports 1-3 shared.
// R12: Timing independent of partner clock phase.
// R13: Input synchronised, oversampled, centre sampled.
// R14: Acknowledge interleaves between outgoing data packets.

`timescale 1ns/10ps
`include "link_regs.svh"

// ----------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------
module link_fifo #(
	parameter int WIDTH = `LINK_DATA_BITS,
	parameter int DEPTH = `LINK_FIFO_DEPTH
) (
	// Clock and reset
	input  logic             ref_clk,
	input  logic             reset,
	// Fill side
	input  logic [WIDTH-1:0] in_data,
	input  logic             in_valid,
	output logic             in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic             out_valid,
	input  logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      count_reg, count_next;
	logic             full_reg, full_next, valid_reg, valid_next;
	logic [WIDTH-1:0] data_reg, data_next;
	logic             push, pop;

	always_comb
	begin
		push = in_valid && !full_reg;
		pop = valid_reg && out_ready;
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		count_next = count_reg;
		if (push)
		begin
			mem_next[wr_reg] = in_data;
			wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop)
			rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
		full_next = (count_next == (AW + 1)'(DEPTH));
		valid_next = (count_next != '0);
		data_next = mem_next[rd_next];
	end

	always_ff @(posedge ref_clk)
	begin
		mem_reg <= mem_next;
		data_reg <= data_next;
		if (reset)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
			full_reg <= 1'b0;
			valid_reg <= 1'b0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			count_reg <= count_next;
			full_reg <= full_next;
			valid_reg <= valid_next;
		end
	end

	assign in_ready = !full_reg;
	assign out_valid = valid_reg;
	assign out_data = data_reg;

endmodule // link_fifo

// ----------------------------------------------------------------------
// One link port engine
// ----------------------------------------------------------------------
module link_engine #(
	parameter int DEPTH = `LINK_FIFO_DEPTH
) (
	// Clock and reset
	input  logic       ref_clk,
	input  logic       reset,
	// Bit timing
	input  logic [3:0] bit_cycles,
	// Serial lines
	input  logic       serial_rx_line,
	output logic       serial_tx_line,
	// Transmit side
	input  logic [7:0] tx_data,
	input  logic       tx_valid,
	input  logic       tx_last,
	output logic       tx_ready,
	output logic       tx_done,
	// Receive side
	output logic [7:0] rx_data,
	output logic       rx_valid,
	input  logic       rx_ready
);
	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	link_pkg::rx_state_t rx_state_reg, rx_state_next;
	logic       s1_reg, s2_reg, s3_reg, filt_reg, filt_next, prev_reg;
	logic [3:0] rx_timer_reg, rx_timer_next;
	logic [2:0] rx_cnt_reg, rx_cnt_next;
	logic [7:0] rx_byte_reg, rx_byte_next;
	logic       push_reg, push_next, ack_seen_reg, ack_seen_next;
	logic       fifo_room;

	always_comb
	begin
		filt_next = (s2_reg == s3_reg) ? s2_reg : filt_reg; // [R12] [R13]
		rx_state_next = rx_state_reg;
		rx_timer_next = (rx_timer_reg != 4'h0) ? rx_timer_reg - 4'h1 : rx_timer_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_byte_next = rx_byte_reg;
		push_next = 1'b0;
		ack_seen_next = 1'b0;
		unique case (rx_state_reg)
			link_pkg::RX_IDLE:
				if (filt_reg && !prev_reg)
				begin
					rx_state_next = link_pkg::RX_FLAG;
					rx_timer_next = bit_cycles + (bit_cycles >> 1) - 4'(`LINK_SAMPLE_LEAD); // [R13]
				end
			link_pkg::RX_FLAG:
				if (rx_timer_reg == 4'h0)
				begin
					rx_timer_next = bit_cycles - 4'h1;
					if (filt_reg)
					begin
						rx_state_next = link_pkg::RX_DATA;
						rx_cnt_next = 3'h0;
					end
					else
					begin
						rx_state_next = link_pkg::RX_IDLE;
						ack_seen_next = 1'b1; // [R5]
					end
				end
			link_pkg::RX_DATA:
				if (rx_timer_reg == 4'h0)
				begin
					rx_byte_next = {filt_reg, rx_byte_reg[7:1]}; // [R4]
					rx_cnt_next = rx_cnt_reg + 3'h1;
					rx_timer_next = bit_cycles - 4'h1;
					if (rx_cnt_reg == 3'(`LINK_DATA_BITS - 1))
						rx_state_next = link_pkg::RX_STOP;
				end
			link_pkg::RX_STOP:
				if (rx_timer_reg == 4'h0)
				begin
					rx_state_next = link_pkg::RX_IDLE;
					push_next = 1'b1;
				end
			default:
				rx_state_next = link_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			filt_reg <= 1'b0;
			prev_reg <= 1'b0;
			rx_state_reg <= link_pkg::RX_IDLE;
			rx_timer_reg <= 4'h0;
			rx_cnt_reg <= 3'h0;
			rx_byte_reg <= 8'h00;
			push_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= serial_rx_line;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			prev_reg <= filt_reg;
			rx_state_reg <= rx_state_next;
			rx_timer_reg <= rx_timer_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_byte_reg <= rx_byte_next;
			push_reg <= push_next;
			ack_seen_reg <= ack_seen_next;
		end
	end

	link_fifo #(
		.WIDTH (`LINK_DATA_BITS),
		.DEPTH (DEPTH)
	) rx_fifo (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.in_data   (rx_byte_reg),
		.in_valid  (push_reg),
		.in_ready  (fifo_room),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	link_pkg::tx_state_t tx_state_reg, tx_state_next;
	logic [10:0] shift_reg, shift_next;
	logic [3:0]  left_reg, left_next, tx_timer_reg, tx_timer_next;
	logic [7:0]  hold_reg, hold_next;
	logic        hold_full_reg, hold_full_next, hold_last_reg, hold_last_next;
	logic        line_reg, line_next, ready_reg, ready_next, done_reg, done_next;
	logic        wait_reg, wait_next, last_sent_reg, last_sent_next;
	logic        ack_pend_reg, ack_pend_next, ack_go, data_go;

	always_comb
	begin
		ack_go = (tx_state_reg == link_pkg::TX_IDLE) && ack_pend_reg && fifo_room; // [R8] [R14]
		data_go = (tx_state_reg == link_pkg::TX_IDLE) && !ack_go && hold_full_reg && !wait_reg; // [R7]
		ack_pend_next = push_reg || (ack_pend_reg && !ack_go); // [R6]
		wait_next = data_go ? 1'b1 : (ack_seen_reg ? 1'b0 : wait_reg); // [R7]
		done_next = ack_seen_reg && wait_reg && last_sent_reg; // [R9]
		hold_next = hold_reg;
		hold_last_next = hold_last_reg;
		hold_full_next = hold_full_reg && !data_go;
		if (tx_valid && ready_reg)
		begin
			hold_next = tx_data;
			hold_last_next = tx_last;
			hold_full_next = 1'b1;
		end
		ready_next = !hold_full_next;
		last_sent_next = data_go ? hold_last_reg : last_sent_reg;
		tx_state_next = tx_state_reg;
		shift_next = shift_reg;
		left_next = left_reg;
		tx_timer_next = (tx_timer_reg != 4'h0) ? tx_timer_reg - 4'h1 : tx_timer_reg;
		unique case (tx_state_reg)
			link_pkg::TX_IDLE:
			begin
				if (ack_go)
				begin
					shift_next = `LINK_ACK_PATTERN; // [R5]
					left_next = 4'(`LINK_ACK_FRAME);
				end
				else if (data_go)
				begin
					shift_next = {`LINK_DATA_STOP, hold_reg, `LINK_DATA_HEAD}; // [R3]
					left_next = 4'(`LINK_DATA_FRAME);
				end
				if (ack_go || data_go)
				begin
					tx_state_next = link_pkg::TX_SEND;
					tx_timer_next = bit_cycles - 4'h1;
				end
			end
			link_pkg::TX_SEND:
				if (tx_timer_reg == 4'h0)
				begin
					if (left_reg == 4'h1)
						tx_state_next = link_pkg::TX_IDLE;
					else
					begin
						shift_next = shift_reg >> 1; // [R4]
						left_next = left_reg - 4'h1;
						tx_timer_next = bit_cycles - 4'h1;
					end
				end
			default:
				tx_state_next = link_pkg::TX_IDLE;
		endcase
		line_next = (tx_state_next == link_pkg::TX_SEND) ? shift_next[0] : 1'b0; // [R2]
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			tx_state_reg <= link_pkg::TX_IDLE;
			shift_reg <= 11'h000;
			left_reg <= 4'h0;
			tx_timer_reg <= 4'h0;
			hold_reg <= 8'h00;
			hold_full_reg <= 1'b0;
			hold_last_reg <= 1'b0;
			line_reg <= 1'b0;
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			wait_reg <= 1'b0;
			last_sent_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
		end
		else
		begin
			tx_state_reg <= tx_state_next;
			shift_reg <= shift_next;
			left_reg <= left_next;
			tx_timer_reg <= tx_timer_next;
			hold_reg <= hold_next;
			hold_full_reg <= hold_full_next;
			hold_last_reg <= hold_last_next;
			line_reg <= line_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			wait_reg <= wait_next;
			last_sent_reg <= last_sent_next;
			ack_pend_reg <= ack_pend_next;
		end
	end

	assign serial_tx_line = line_reg;
	assign tx_ready = ready_reg;
	assign tx_done = done_reg;

endmodule // link_engine

// ----------------------------------------------------------------------
// Device top
// ----------------------------------------------------------------------
module link_device #(
	parameter int PORTS = `LINK_PORTS,
	parameter int DEPTH = `LINK_FIFO_DEPTH
) (
	// Clock and reset
	input  logic                  ref_clk,
	input  logic                  reset,
	// Rate select pins
	input  logic                  global_rate_select,
	input  logic                  port0_rate_select,
	input  logic                  ports123_rate_select,
	// Serial lines
	link_if.device_end            lnk,
	// Transmit side
	input  logic [PORTS-1:0][7:0] tx_data,
	input  logic [PORTS-1:0]      tx_valid,
	input  logic [PORTS-1:0]      tx_last,
	output logic [PORTS-1:0]      tx_ready,
	output logic [PORTS-1:0]      tx_done,
	// Receive side
	output logic [PORTS-1:0][7:0] rx_data,
	output logic [PORTS-1:0]      rx_valid,
	input  logic [PORTS-1:0]      rx_ready
);
	logic [2:0]            p1_reg, p2_reg, p3_reg, sel_reg, sel_next;
	logic [PORTS-1:0][3:0] cyc_reg, cyc_next;

	assign sel_next = (p2_reg & ~(p2_reg ^ p3_reg)) | (sel_reg & (p2_reg ^ p3_reg));

	genvar p;
	generate
		for (p = 0; p < PORTS; p++)
		begin : g_port
			logic port_sel;
			assign port_sel = (p == 0) ? sel_reg[1] : sel_reg[2]; // [R11]
			assign cyc_next[p] = !port_sel ? 4'(`LINK_CLK_HZ / `LINK_RATE_STD) :
				(sel_reg[0] ? 4'(`LINK_CLK_HZ / `LINK_RATE_FAST) :
				4'(`LINK_CLK_HZ / `LINK_RATE_SLOW)); // [R10]

			link_engine #(.DEPTH (DEPTH)) engine ( // [R1]
				.ref_clk        (ref_clk),
				.reset          (reset),
				.bit_cycles     (cyc_reg[p]),
				.serial_rx_line (lnk.host_to_dev[p]),
				.serial_tx_line (lnk.dev_to_host[p]),
				.tx_data        (tx_data[p]),
				.tx_valid       (tx_valid[p]),
				.tx_last        (tx_last[p]),
				.tx_ready       (tx_ready[p]),
				.tx_done        (tx_done[p]),
				.rx_data        (rx_data[p]),
				.rx_valid       (rx_valid[p]),
				.rx_ready       (rx_ready[p])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			p1_reg <= 3'h0;
			p2_reg <= 3'h0;
			p3_reg <= 3'h0;
			sel_reg <= 3'h0;
			cyc_reg <= '{default: 4'(`LINK_CLK_HZ / `LINK_RATE_STD)};
		end
		else
		begin
			p1_reg <= {ports123_rate_select, port0_rate_select, global_rate_select};
			p2_reg <= p1_reg;
			p3_reg <= p2_reg;
			sel_reg <= sel_next;
			cyc_reg <= cyc_next;
		end
	end

endmodule // link_device

/* rtl/link_host.sv */
// Purpose: Partner end: identical link ports facing the device.
// Assumes: Reuses the port engine of the device end.
// Notes: One rate select per partner port.

`timescale 1ns/10ps
`include "link_regs.svh"

module link_host #(
	parameter int PORTS = `LINK_PORTS,
	parameter int DEPTH = `LINK_FIFO_DEPTH
) (
	// Clock and reset
	input  logic                  ref_clk,
	input  logic                  reset,
	// Rate select pins
	input  logic                  global_rate_select,
	input  logic [PORTS-1:0]      per_port_rate_select,
	// Serial lines
	link_if.host_end              lnk,
	// Transmit side
	input  logic [PORTS-1:0][7:0] tx_data,
	input  logic [PORTS-1:0]      tx_valid,
	input  logic [PORTS-1:0]      tx_last,
	output logic [PORTS-1:0]      tx_ready,
	output logic [PORTS-1:0]      tx_done,
	// Receive side
	output logic [PORTS-1:0][7:0] rx_data,
	output logic [PORTS-1:0]      rx_valid,
	input  logic [PORTS-1:0]      rx_ready
);
	logic [PORTS:0]        p1_reg, p2_reg, p3_reg, sel_reg, sel_next;
	logic [PORTS-1:0][3:0] cyc_reg, cyc_next;

	assign sel_next = (p2_reg & ~(p2_reg ^ p3_reg)) | (sel_reg & (p2_reg ^ p3_reg));

	genvar p;
	generate
		for (p = 0; p < PORTS; p++)
		begin : g_port
			assign cyc_next[p] = !sel_reg[p + 1] ? 4'(`LINK_CLK_HZ / `LINK_RATE_STD) :
				(sel_reg[0] ? 4'(`LINK_CLK_HZ / `LINK_RATE_FAST) :
				4'(`LINK_CLK_HZ / `LINK_RATE_SLOW)); // [R10]

			link_engine #(.DEPTH (DEPTH)) engine ( // [R6] [R7] [R8]
				.ref_clk        (ref_clk),
				.reset          (reset),
				.bit_cycles     (cyc_reg[p]),
				.serial_rx_line (lnk.dev_to_host[p]),
				.serial_tx_line (lnk.host_to_dev[p]),
				.tx_data        (tx_data[p]),
				.tx_valid       (tx_valid[p]),
				.tx_last        (tx_last[p]),
				.tx_ready       (tx_ready[p]),
				.tx_done        (tx_done[p]),
				.rx_data        (rx_data[p]),
				.rx_valid       (rx_valid[p]),
				.rx_ready       (rx_ready[p])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			p1_reg <= '0;
			p2_reg <= '0;
			p3_reg <= '0;
			sel_reg <= '0;
			cyc_reg <= '{default: 4'(`LINK_CLK_HZ / `LINK_RATE_STD)};
		end
		else
		begin
			p1_reg <= {per_port_rate_select, global_rate_select};
			p2_reg <= p1_reg;
			p3_reg <= p2_reg;
			sel_reg <= sel_next;
			cyc_reg <= cyc_next;
		end
	end

endmodule // link_host

/* rtl/link_if.sv */
// Purpose: Serial lines joining the device end and the partner end.
// Assumes: One line in each direction per port.
// Notes: No clocking block; the lines are plain levels.

`timescale 1ns/10ps
`include "link_regs.svh"

interface link_if #(parameter int PORTS = `LINK_PORTS);

	// ------------------------------------------------------------------
	// Lines
	// ------------------------------------------------------------------
	logic [PORTS-1:0] dev_to_host;
	logic [PORTS-1:0] host_to_dev;

	modport device_end (output dev_to_host, input host_to_dev);
	modport host_end (input dev_to_host, output host_to_dev);

endinterface

/* rtl/link_pkg.sv */
// Purpose: Types shared by both link ends.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are one-hot.

package link_pkg;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_FLAG = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} tx_state_t;

endpackage

/* rtl/link_regs.svh */
// Purpose: Named constants for the serial link port pair.
// Assumes: Both ends run on ref_clk at 40 MHz.
// Notes: Included by link_device, link_host and link_if; guarded against double inclusion.

`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

// ----------------------------------------------------------------------
// Clock and bit rates
// ----------------------------------------------------------------------
`define LINK_CLK_HZ        40000000
`define LINK_RATE_SLOW     5000000
`define LINK_RATE_STD      10000000
`define LINK_RATE_FAST     20000000
`define LINK_SAMPLE_LEAD   1

// ----------------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------------
`define LINK_DATA_BITS     8
`define LINK_DATA_FRAME    11
`define LINK_ACK_FRAME     2
`define LINK_DATA_HEAD     2'h3
`define LINK_DATA_STOP     1'h0
`define LINK_ACK_PATTERN   11'h001

// ----------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------
`define LINK_PORTS         4
`define LINK_FIFO_DEPTH    16

`endif
